// >>> trim_bank_pkg.sv
// constants shared by the offset trim bank and its per-core output stage
// assumes a 32-bit apb bus with word-aligned registers
package trim_bank_pkg;
  localparam int unsigned TRIM_COUNT = 7;
  localparam int unsigned REG_WIDTH = 16;
  localparam int unsigned TRIM_WIDTH = 12;
  localparam int unsigned TRIM_LSB = 0;
  localparam int unsigned TRIM_MSB = 11;
  localparam int unsigned APB_ADDR_WIDTH = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONV1_OFFSET_TRIM = 10'h332;
  localparam logic [9:0] IDX_CONV2_INPUT_A_OFFSET_TRIM = 10'h334;
  localparam logic [9:0] IDX_CONV2_INPUT_B_OFFSET_TRIM = 10'h336;
  localparam logic [9:0] IDX_CONV3_INPUT_C_OFFSET_TRIM = 10'h338;
  localparam logic [9:0] IDX_CONV3_INPUT_D_OFFSET_TRIM = 10'h33a;
  localparam logic [9:0] IDX_CONV4_OFFSET_TRIM = 10'h33c;
  localparam logic [9:0] IDX_CONV5_OFFSET_TRIM = 10'h33e;
  localparam logic [9:0] IDX_TRIM_STATUS = 10'h340;
  // storage slots inside the bank; SLOT_NONE marks an address with no slot
  localparam int unsigned SLOT_CONV1 = 0;
  localparam int unsigned SLOT_CONV2_A = 1;
  localparam int unsigned SLOT_CONV2_B = 2;
  localparam int unsigned SLOT_CONV3_C = 3;
  localparam int unsigned SLOT_CONV3_D = 4;
  localparam int unsigned SLOT_CONV4 = 5;
  localparam int unsigned SLOT_CONV5 = 6;
  localparam int unsigned SLOT_NONE = 7;
  localparam logic [15:0] TRIM_RESET_VALUE = 16'h0000;
  localparam logic [11:0] OFFSET_RESET_VALUE = 12'h000;
  // status bits
  localparam int unsigned STAT_FUSE_LOADED_BIT = 0;
  localparam int unsigned STAT_CAL_BUSY_BIT = 1;
endpackage

// >>> trim_select_stage.sv
// one core's offset output stage: picks the trim for the sampled input
// assumes trims and select come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module trim_select_stage
  import trim_bank_pkg::*;
#(
  parameter int unsigned WIDTH = TRIM_WIDTH
)
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic [WIDTH-1:0] trim_primary_i,
  input wire logic [WIDTH-1:0] trim_alt_i,
  input wire logic use_alt_i,
  output logic [WIDTH-1:0] offset_o
);
  // refused at elaboration, a zero-width offset has no meaning
  if (WIDTH < 1)
  begin : g_width_check
    $error("trim_select_stage: WIDTH must be at least 1");
  end

  // registered so the datapath sees a glitch-free value per clock
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      offset_o <= WIDTH'(OFFSET_RESET_VALUE);
    end
    else
    begin
      offset_o <= use_alt_i ? trim_alt_i : trim_primary_i;
    end
  end
endmodule
`default_nettype wire

// >>> converter_offset_trim_bank.sv
// offset trim register bank for converter cores 1 to 5, apb slave
// assumes fuse defaults and input selects come from logic on SYS_CLK_I
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module converter_offset_trim_bank
  import trim_bank_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = APB_ADDR_WIDTH
)
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [ADDR_WIDTH-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [TRIM_COUNT*REG_WIDTH-1:0] FUSE_TRIM_I,
  input wire logic FUSE_VALID_I,
  input wire logic CAL_OFFSET_BUSY_I,
  input wire logic CORE2_SAMPLES_B_I,
  input wire logic CORE3_SAMPLES_D_I,
  output logic [TRIM_WIDTH-1:0] OFFSET_CORE1_O,
  output logic [TRIM_WIDTH-1:0] OFFSET_CORE2_O,
  output logic [TRIM_WIDTH-1:0] OFFSET_CORE3_O,
  output logic [TRIM_WIDTH-1:0] OFFSET_CORE4_O,
  output logic [TRIM_WIDTH-1:0] OFFSET_CORE5_O
);
  // refused at elaboration: the decode slices PADDR_I[11:2]
  if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32)
  begin : g_addr_width_check
    $error("converter_offset_trim_bank: ADDR_WIDTH must be 12 to 32");
  end

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [REG_WIDTH-1:0] trim_q [TRIM_COUNT];
  logic fuse_loaded_q;
  logic [2:0] slot;
  logic status_hit;
  logic addr_ok;
  logic setup;
  logic access_done;

  function automatic logic [2:0] slot_of(input logic [9:0] idx);
    unique case (idx)
      IDX_CONV1_OFFSET_TRIM: slot_of = 3'(SLOT_CONV1);
      IDX_CONV2_INPUT_A_OFFSET_TRIM: slot_of = 3'(SLOT_CONV2_A);
      IDX_CONV2_INPUT_B_OFFSET_TRIM: slot_of = 3'(SLOT_CONV2_B);
      IDX_CONV3_INPUT_C_OFFSET_TRIM: slot_of = 3'(SLOT_CONV3_C);
      IDX_CONV3_INPUT_D_OFFSET_TRIM: slot_of = 3'(SLOT_CONV3_D);
      IDX_CONV4_OFFSET_TRIM: slot_of = 3'(SLOT_CONV4);
      IDX_CONV5_OFFSET_TRIM: slot_of = 3'(SLOT_CONV5);
      default: slot_of = 3'(SLOT_NONE);
    endcase
  endfunction

  // upper address bits beyond the index must be zero, low two bits too
  always_comb
  begin
    slot = slot_of(PADDR_I[11:2]);
    status_hit = (PADDR_I[11:2] == IDX_TRIM_STATUS);
    addr_ok = (PADDR_I[1:0] == 2'h0) && (ADDR_WIDTH == 12 || (PADDR_I >> 12) == '0);
    if (!addr_ok)
    begin
      slot = 3'(SLOT_NONE);
      status_hit = 1'b0;
    end
    setup = PSEL_I && !PENABLE_I;
    access_done = PSEL_I && PENABLE_I && PREADY_O;
  end

  // ****************************************************************
  // apb answer: one access cycle, no wait states
  // ****************************************************************
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      PREADY_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= setup;
    end
  end

  // trim access during calibration is answered with an error and dropped,
  // which keeps a misbehaving driver from disturbing the engine
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      PSLVERR_O <= 1'b0;
    end
    else if (setup)
    begin
      PSLVERR_O <= (slot == 3'(SLOT_NONE) && !status_hit) ||
                   (slot != 3'(SLOT_NONE) && CAL_OFFSET_BUSY_I);
    end
    else
    begin
      PSLVERR_O <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      PRDATA_O <= 32'h0000_0000;
    end
    else if (setup && !PWRITE_I)
    begin
      PRDATA_O <= 32'h0000_0000;
      if (status_hit)
      begin
        PRDATA_O[STAT_FUSE_LOADED_BIT] <= fuse_loaded_q;
        PRDATA_O[STAT_CAL_BUSY_BIT] <= CAL_OFFSET_BUSY_I;
      end
      else if (slot != 3'(SLOT_NONE) && !CAL_OFFSET_BUSY_I)
      begin
        PRDATA_O[REG_WIDTH-1:0] <= trim_q[slot];
      end
    end
    else if (access_done)
    begin
      PRDATA_O <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // trim storage
  // ****************************************************************
  // fuse defaults are taken once, at the first valid after reset; until
  // then the registers hold the plain reset value or the last apb write
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      fuse_loaded_q <= 1'b0;
    end
    else if (FUSE_VALID_I)
    begin
      fuse_loaded_q <= 1'b1;
    end
  end

  // the reserved nibble is stored as written; software keeps it zero
  for (genvar i = 0; i < TRIM_COUNT; i++)
  begin : g_trim
    always_ff @(posedge SYS_CLK_I)
    begin
      if (RESET_I)
      begin
        trim_q[i] <= TRIM_RESET_VALUE;
      end
      else if (!fuse_loaded_q && FUSE_VALID_I)
      begin
        trim_q[i] <= FUSE_TRIM_I[i*REG_WIDTH +: REG_WIDTH];
      end
      else if (access_done && PWRITE_I && !PSLVERR_O && !CAL_OFFSET_BUSY_I &&
               slot == 3'(i))
      begin
        trim_q[i] <= PWDATA_I[REG_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // per-core offset outputs
  // ****************************************************************
  // fields leave as plain unsigned values, no sign extension
  trim_select_stage #(.WIDTH(TRIM_WIDTH)) u_core1
  (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .trim_primary_i(trim_q[SLOT_CONV1][TRIM_MSB:TRIM_LSB]),
    .trim_alt_i(trim_q[SLOT_CONV1][TRIM_MSB:TRIM_LSB]),
    .use_alt_i(1'b0),
    .offset_o(OFFSET_CORE1_O)
  );

  trim_select_stage #(.WIDTH(TRIM_WIDTH)) u_core2
  (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .trim_primary_i(trim_q[SLOT_CONV2_A][TRIM_MSB:TRIM_LSB]),
    .trim_alt_i(trim_q[SLOT_CONV2_B][TRIM_MSB:TRIM_LSB]),
    .use_alt_i(CORE2_SAMPLES_B_I),
    .offset_o(OFFSET_CORE2_O)
  );

  trim_select_stage #(.WIDTH(TRIM_WIDTH)) u_core3
  (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .trim_primary_i(trim_q[SLOT_CONV3_C][TRIM_MSB:TRIM_LSB]),
    .trim_alt_i(trim_q[SLOT_CONV3_D][TRIM_MSB:TRIM_LSB]),
    .use_alt_i(CORE3_SAMPLES_D_I),
    .offset_o(OFFSET_CORE3_O)
  );

  // select tied off: these cores have one trim each
  trim_select_stage #(.WIDTH(TRIM_WIDTH)) u_core4
  (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .trim_primary_i(trim_q[SLOT_CONV4][TRIM_MSB:TRIM_LSB]),
    .trim_alt_i(trim_q[SLOT_CONV4][TRIM_MSB:TRIM_LSB]),
    .use_alt_i(1'b0),
    .offset_o(OFFSET_CORE4_O)
  );

  trim_select_stage #(.WIDTH(TRIM_WIDTH)) u_core5
  (
    .SYS_CLK_I(SYS_CLK_I),
    .RESET_I(RESET_I),
    .trim_primary_i(trim_q[SLOT_CONV5][TRIM_MSB:TRIM_LSB]),
    .trim_alt_i(trim_q[SLOT_CONV5][TRIM_MSB:TRIM_LSB]),
    .use_alt_i(1'b0),
    .offset_o(OFFSET_CORE5_O)
  );
endmodule
`default_nettype wire

// >>> trim_bank_checker.sv
// assertions on the apb side and offsets of the trim bank
// assumes a bind onto converter_offset_trim_bank
`timescale 1ns/1ps
`default_nettype none
module trim_bank_checker
  import trim_bank_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = APB_ADDR_WIDTH
)
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [ADDR_WIDTH-1:0] PADDR_I,
  input wire logic CAL_OFFSET_BUSY_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [TRIM_WIDTH-1:0] OFFSET_CORE1_O,
  input wire logic [TRIM_WIDTH-1:0] OFFSET_CORE5_O
);
  // ****************
  // trim address hit
  // ****************
  logic trim_hit;
  assign trim_hit = PADDR_I >= 12'hcc8 && PADDR_I <= 12'hcf8 && PADDR_I[2:0] == 3'h0;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  a_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  a_ready_cause: assert property (!PSEL_I |=> !PREADY_O)
    else $error("ready without request");
  a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
    else $error("read data outside access");
  a_upper_zero: assert property (PREADY_O |-> PRDATA_O[31:16] == 16'h0)
    else $error("upper half not zero");
  a_err_qual: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  a_busy_refuse: assert property (PSEL_I && !PENABLE_I && CAL_OFFSET_BUSY_I && trim_hit
    |=> PSLVERR_O && PRDATA_O == 32'h0) else $error("busy access not refused");
  a_reset_zero: assert property ($fell(RESET_I) |-> OFFSET_CORE1_O == 12'h0
    && OFFSET_CORE5_O == 12'h0) else $error("offset not cleared by reset");
endmodule
`default_nettype wire

// >>> test_converter_offset_trim_bank.sv
// self-checking bench for the offset trim bank over apb
// assumes the checker file is compiled first
`timescale 1ns/1ps
`default_nettype none
module test_converter_offset_trim_bank import trim_bank_pkg::*;;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fv = 0, busy = 0, s2 = 0, s3 = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata, rnd = 32'h9f26;
  logic [111:0] fuse = 0;
  logic pready, perr, e;
  logic [11:0] oc1, oc2, oc3, oc4, oc5;
  int fail_count = 0, checks = 0, mdl [7];
  localparam logic [11:0] BASE = {IDX_CONV1_OFFSET_TRIM, 2'b00};
  converter_offset_trim_bank dut_u (.SYS_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(perr), .FUSE_TRIM_I(fuse), .FUSE_VALID_I(fv),
    .CAL_OFFSET_BUSY_I(busy), .CORE2_SAMPLES_B_I(s2), .CORE3_SAMPLES_D_I(s3),
    .OFFSET_CORE1_O(oc1), .OFFSET_CORE2_O(oc2), .OFFSET_CORE3_O(oc3),
    .OFFSET_CORE4_O(oc4), .OFFSET_CORE5_O(oc5));
  initial forever #2.5 clk = ~clk;
  initial
  begin
    #60000;
    fail_count++;
    close_out();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("mismatches %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ***************************
  // apb transfer, holds to ready
  // ***************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // ready, data and error are taken at the rising edge that sees ready high
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    if (pready !== 1'b1)
      fail_count++;
    rd = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task outs;
    repeat (3) @(posedge clk);
    chk(oc1, mdl[0] & 'hfff);
    chk(oc2, (s2 ? mdl[2] : mdl[1]) & 'hfff);
    chk(oc3, (s3 ? mdl[4] : mdl[3]) & 'hfff);
    chk(oc4, mdl[5] & 'hfff);
    chk(oc5, mdl[6] & 'hfff);
  endtask
  task readback;
    for (int i = 0; i < 7; i++)
    begin
      apb(0, BASE + 12'(8 * i), 0);
      chk(rd, mdl[i]);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    apb(0, BASE + 12'h28, 0);
    chk(rd, 0);
    for (int i = 0; i < 7; i++)
    begin
      rnd = lfsr(rnd);
      fuse[16 * i +: 16] <= rnd[15:0];
      mdl[i] = rnd[15:0];
    end
    fv <= 1;
    @(posedge clk);
    fv <= 0;
    // a later valid pulse must not reload the defaults
    fuse <= ~fuse;
    @(posedge clk);
    fv <= 1;
    @(posedge clk);
    fv <= 0;
    outs();
    readback();
    for (int i = 0; i < 7; i++)
    begin
      rnd = lfsr(rnd);
      mdl[i] = rnd[11:0];
      apb(1, BASE + 12'(8 * i), mdl[i]);
    end
    for (int s = 0; s < 2; s++)
    begin
      s2 <= s[0];
      s3 <= s[0];
      outs();
    end
    busy <= 1;
    apb(1, BASE + 12'h28, 32'h0123);
    chk(e, 1);
    apb(0, BASE + 12'h28, 0);
    chk(rd, 0);
    chk(e, 1);
    apb(0, 12'hd00, 0);
    chk(rd, 3);
    chk(e, 0);
    busy <= 0;
    readback();
    outs();
    apb(0, 12'h004, 0);
    chk(e, 1);
    apb(0, BASE + 12'h2, 0);
    chk(e, 1);
    // mid-run reset: plain reset value until the next valid reloads the fuses
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 7; i++)
      mdl[i] = 0;
    readback();
    outs();
    apb(0, 12'hd00, 0);
    chk(rd, 0);
    fv <= 1;
    @(posedge clk);
    fv <= 0;
    for (int i = 0; i < 7; i++)
      mdl[i] = fuse[16 * i +: 16];
    readback();
    outs();
    close_out();
  end
endmodule
bind converter_offset_trim_bank trim_bank_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .SYS_CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PADDR_I, .CAL_OFFSET_BUSY_I, .PRDATA_O,
  .PREADY_O, .PSLVERR_O, .OFFSET_CORE1_O, .OFFSET_CORE5_O);
`default_nettype wire
